//--- hdl/serial_defs.svh
// constants for the serial controller common register set
// assumes a byte-addressed register port with 32-bit data words
//
// Contract
// R1 - enable bits are read/write; a cleared enable suppresses its interrupt
// R2 - bit 14 gates parity error, bit 13 framing error; first unit only
// R3 - bits 12..9 gate tx B, tx A, rx B, rx A buffer unloaded
// R4 - bits 8..5 gate no-ack, command done, byte sent, byte received
// R5 - bit 4 raises an interrupt while the underrun flag is set
// R6 - bit 3 raises overrun from serial overrun or either buffer overrun
// R7 - bit 2 raises line idle from the active serial mode
// R8 - bit 1 raises transmit space from the active serial mode
// R9 - bit 0 raises receive available from the active serial mode
// R10 - trigger bit 2: idle interrupt on edge (0) or level (1)
// R11 - trigger bit 1: transmit space interrupt on edge or level
// R12 - trigger bit 0: receive available interrupt on edge or level
// R13 - a data port write pushes bits 7..0 into the transmit fifo
// R14 - a data port read pops the receive fifo and clears overrun
// R15 - uart mode read loads error status of next byte, clears if empty
// R16 - mode field: 00 none, 01 uart, 10 spi, 11 i2c
// R17 - the second unit offers no uart mode
// R18 - software writes reserved bits as zero; everything resets to zero
// R19 - receive available is set while unread received data remain
// R20 - one request: or of enabled conditions; edge sources pulse on rise
// R21 - data port reads zero above bit 7; upper write bits ignored
`ifndef SERIAL_DEFS_SVH
`define SERIAL_DEFS_SVH

// register byte offsets
`define OFS_IRQ_EN 16'hA848
`define OFS_IRQ_TRIG 16'hA854
`define OFS_DATA 16'hC83C
`define OFS_MODE 16'hC854
`define OFS_STATUS 16'hC860

// field widths and positions
`define EN_BITS 15
`define TRIG_BITS 3
`define MODE_BITS 2
`define BYTE_BITS 8
`define BIT_PARITY_EN 14
`define BIT_FRAME_EN 13
`define BIT_UNDERRUN 4
`define BIT_OVERRUN 3
`define BIT_IDLE 2
`define BIT_TXSPACE 1
`define BIT_RXAVAIL 0

// mode codes
`define MODE_NONE 2'h0
`define MODE_UART 2'h1
`define MODE_SPI 2'h2
`define MODE_I2C 2'h3

// reset values
`define RST_WORD 32'h0000_0000
`define RST_EN 15'h0000
`define RST_TRIG 3'h0

// fifo geometry
`define FIFO_AW 2
`define FIFO_DEPTH 3'h4
`define RX_W 10

`endif

//--- hdl/serial_pkg.sv
// types shared by the serial controller common register set
// assumes serial_defs.svh supplies the widths
`include "serial_defs.svh"
package serial_pkg;
   typedef logic [`BYTE_BITS-1:0] byte_t;
   typedef logic [`MODE_BITS-1:0] mode_t;
   typedef logic [`EN_BITS-1:0] irq_vec_t;
   typedef logic [`FIFO_AW-1:0] ptr_t;
   typedef logic [`FIFO_AW:0] count_t;
endpackage

//--- hdl/fifo_mem.sv
// small fifo storage with one write and one registered read port
// assumes pointers are kept by the instantiating logic
`timescale 1ns/1ps
module fifo_mem #(
   parameter int DW = 8,
   parameter int AW = 2
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [DW-1:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [DW-1:0] rdData
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge mclk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // write-through keeps the head valid when writing into an empty queue
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdData <= '0;
      end else if (wrEn && (wrAddr == rdAddr)) begin
         rdData <= wrData;
      end else begin
         rdData <= mem[rdAddr];
      end
   end
endmodule // fifo_mem

//--- hdl/irq_trigger.sv
// edge or level qualifier for one interrupt condition
// assumes cond comes from logic on the same clock
`timescale 1ns/1ps
module irq_trigger (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cond,
   input wire logic levelMode,
   output logic hit
);
   logic cond_ff;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cond_ff <= 1'b0;
      end else begin
         cond_ff <= cond;
      end
   end

   // level follows the condition, edge only on its rise
   assign hit = levelMode ? cond : (cond & ~cond_ff); // see R20
endmodule // irq_trigger

//--- hdl/serial_ctrl_common_regs.sv
// common registers of one serial controller unit
// assumes serializers, i2c engine and dma run on mclk
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "serial_defs.svh"
module serial_ctrl_common_regs import serial_pkg::*; #(
   parameter bit FIRST_UNIT = 1'b1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic txPop,
   input wire logic txShiftIdle,
   output logic [7:0] txByte,
   output logic txValid,
   input wire logic rxPush,
   input wire logic [7:0] rxByte,
   input wire logic rxParErr,
   input wire logic rxFrmErr,
   input wire logic noAckFlag,
   input wire logic busCmdDoneFlag,
   input wire logic byteSentFlag,
   input wire logic byteGotFlag,
   input wire logic txBufBUnloaded,
   input wire logic txBufAUnloaded,
   input wire logic rxBufBUnloaded,
   input wire logic rxBufAUnloaded,
   input wire logic underrunFlag,
   input wire logic dmaOverrunA,
   input wire logic dmaOverrunB,
   output logic [1:0] modeSel,
   output logic irqReq,
   output logic overrunFlag,
   output logic parityErrFlag,
   output logic frameErrFlag
);

   ////////////////////////////////////////////////////////////////////////
   // register decode

   logic wrEn;
   logic wrTrig;
   logic wrData;
   logic wrMode;
   logic rdData;
   irq_vec_t enMask;
   irq_vec_t irqEn_ff;
   logic [`TRIG_BITS-1:0] trig_ff;
   mode_t mode_ff;
   mode_t reqMode;

   assign wrEn = regWr && (regAddr == `OFS_IRQ_EN);
   assign wrTrig = regWr && (regAddr == `OFS_IRQ_TRIG);
   assign wrData = regWr && (regAddr == `OFS_DATA);
   assign wrMode = regWr && (regAddr == `OFS_MODE);
   assign rdData = regRd && (regAddr == `OFS_DATA);
   assign reqMode = mode_t'(regWrData[`MODE_BITS-1:0]);

   // error enables do not exist in the second unit
   assign enMask = FIRST_UNIT ? {`EN_BITS{1'b1}} :
      ~((irq_vec_t'(1) << `BIT_PARITY_EN) |
        (irq_vec_t'(1) << `BIT_FRAME_EN)); // see R2

   ////////////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irqEn_ff <= `RST_EN; // see R18
      end else if (wrEn) begin
         irqEn_ff <= regWrData[`EN_BITS-1:0] & enMask; // see R1
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         trig_ff <= `RST_TRIG;
      end else if (wrTrig) begin
         trig_ff <= regWrData[`TRIG_BITS-1:0]; // see R10
      end
   end

   // uart request is refused in the second unit, mode stays as it was
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_ff <= `MODE_NONE;
      end else if (wrMode) begin
         if (FIRST_UNIT || (reqMode != `MODE_UART)) begin // see R17
            mode_ff <= reqMode; // see R16
         end
      end
   end

   assign modeSel = mode_ff;

   logic uartMode;
   logic serialMode;

   assign uartMode = FIRST_UNIT && (mode_ff == `MODE_UART);
   assign serialMode = uartMode || (mode_ff == `MODE_SPI);

   ////////////////////////////////////////////////////////////////////////
   // transmit fifo

   ptr_t txWrPtr_ff;
   ptr_t txRdPtr_ff;
   count_t txCount_ff;
   count_t nxt_txCount;
   logic txPush;
   logic txTake;
   ptr_t txRdAddr;
   logic txValid_ff;

   assign txPush = wrData && (txCount_ff != `FIFO_DEPTH); // see R13
   assign txTake = txPop && (txCount_ff != '0);
   assign txRdAddr = txTake ? ptr_t'(txRdPtr_ff + 1'b1) : txRdPtr_ff;

   always_comb begin
      nxt_txCount = txCount_ff;
      if (txPush && !txTake) begin
         nxt_txCount = count_t'(txCount_ff + 1'b1);
      end else if (txTake && !txPush) begin
         nxt_txCount = count_t'(txCount_ff - 1'b1);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         txWrPtr_ff <= '0;
         txRdPtr_ff <= '0;
         txCount_ff <= '0;
         txValid_ff <= 1'b0;
      end else begin
         if (txPush) begin
            txWrPtr_ff <= ptr_t'(txWrPtr_ff + 1'b1);
         end
         txRdPtr_ff <= txRdAddr;
         txCount_ff <= nxt_txCount;
         txValid_ff <= (nxt_txCount != '0);
      end
   end

   assign txValid = txValid_ff;

   fifo_mem #(
      .DW(`BYTE_BITS),
      .AW(`FIFO_AW)
   ) txMem (
      .mclk(mclk),
      .nrst(nrst),
      .wrEn(txPush),
      .wrAddr(txWrPtr_ff),
      .wrData(regWrData[`BYTE_BITS-1:0]), // see R21
      .rdAddr(txRdAddr),
      .rdData(txByte)
   );

   ////////////////////////////////////////////////////////////////////////
   // receive fifo

   ptr_t rxWrPtr_ff;
   ptr_t rxRdPtr_ff;
   count_t rxCount_ff;
   count_t nxt_rxCount;
   logic rxStore;
   logic rxTake;
   logic rxLost;
   ptr_t rxRdAddr;
   logic [`RX_W-1:0] rxHead;

   assign rxStore = rxPush && (rxCount_ff != `FIFO_DEPTH);
   assign rxLost = rxPush && (rxCount_ff == `FIFO_DEPTH);
   assign rxTake = rdData && (rxCount_ff != '0); // see R14
   assign rxRdAddr = rxTake ? ptr_t'(rxRdPtr_ff + 1'b1) : rxRdPtr_ff;

   always_comb begin
      nxt_rxCount = rxCount_ff;
      if (rxStore && !rxTake) begin
         nxt_rxCount = count_t'(rxCount_ff + 1'b1);
      end else if (rxTake && !rxStore) begin
         nxt_rxCount = count_t'(rxCount_ff - 1'b1);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rxWrPtr_ff <= '0;
         rxRdPtr_ff <= '0;
         rxCount_ff <= '0;
      end else begin
         if (rxStore) begin
            rxWrPtr_ff <= ptr_t'(rxWrPtr_ff + 1'b1);
         end
         rxRdPtr_ff <= rxRdAddr;
         rxCount_ff <= nxt_rxCount;
      end
   end

   fifo_mem #(
      .DW(`RX_W),
      .AW(`FIFO_AW)
   ) rxMem (
      .mclk(mclk),
      .nrst(nrst),
      .wrEn(rxStore),
      .wrAddr(rxWrPtr_ff),
      .wrData({rxFrmErr, rxParErr, rxByte}),
      .rdAddr(rxRdAddr),
      .rdData(rxHead)
   );

   ////////////////////////////////////////////////////////////////////////
   // overrun and uart error status

   logic overrun_ff;
   logic loadTags_ff;
   logic parity_ff;
   logic frame_ff;

   // a lost byte in the same cycle as the clearing read wins
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         overrun_ff <= 1'b0;
      end else if (rxLost) begin
         overrun_ff <= 1'b1;
      end else if (rdData) begin
         overrun_ff <= 1'b0; // see R14
      end
   end

   // head tags are valid one cycle after the pop or first store
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         loadTags_ff <= 1'b0;
      end else begin
         loadTags_ff <= rxTake || (rxStore && (rxCount_ff == '0));
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         parity_ff <= 1'b0;
         frame_ff <= 1'b0;
      end else if (!uartMode) begin
         parity_ff <= 1'b0;
         frame_ff <= 1'b0;
      end else if (loadTags_ff) begin
         parity_ff <= (rxCount_ff != '0) && rxHead[`BYTE_BITS]; // see R15
         frame_ff <= (rxCount_ff != '0) && rxHead[`BYTE_BITS+1];
      end
   end

   assign overrunFlag = overrun_ff;
   assign parityErrFlag = parity_ff;
   assign frameErrFlag = frame_ff;

   ////////////////////////////////////////////////////////////////////////
   // interrupt conditions

   logic idleCond;
   logic txSpaceCond;
   logic rxAvailCond;
   irq_vec_t cond;
   irq_vec_t hit;
   logic irq_ff;

   assign idleCond = serialMode && (txCount_ff == '0) && txShiftIdle; // see R7
   assign txSpaceCond = serialMode && (txCount_ff != `FIFO_DEPTH); // see R8
   assign rxAvailCond = serialMode && (rxCount_ff != '0); // see R9 R19

   always_comb begin
      cond = '0;
      cond[14] = parity_ff; // see R2
      cond[13] = frame_ff;
      cond[12] = txBufBUnloaded; // see R3
      cond[11] = txBufAUnloaded;
      cond[10] = rxBufBUnloaded;
      cond[9] = rxBufAUnloaded;
      cond[8] = noAckFlag; // see R4
      cond[7] = busCmdDoneFlag;
      cond[6] = byteSentFlag;
      cond[5] = byteGotFlag;
      cond[`BIT_UNDERRUN] = underrunFlag; // see R5
      cond[`BIT_OVERRUN] = (serialMode && overrun_ff) ||
         dmaOverrunA || dmaOverrunB; // see R6
      cond[`BIT_IDLE] = idleCond;
      cond[`BIT_TXSPACE] = txSpaceCond;
      cond[`BIT_RXAVAIL] = rxAvailCond;
   end

   assign hit[`EN_BITS-1:`TRIG_BITS] = cond[`EN_BITS-1:`TRIG_BITS];

   genvar gi;
   generate
      for (gi = 0; gi < `TRIG_BITS; gi++) begin : gTrig
         irq_trigger trigUnit (
            .mclk(mclk),
            .nrst(nrst),
            .cond(cond[gi]),
            .levelMode(trig_ff[gi]), // see R10 R11 R12
            .hit(hit[gi])
         );
      end
   endgenerate

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(hit & irqEn_ff); // see R1 R20
      end
   end

   assign irqReq = irq_ff;

   ////////////////////////////////////////////////////////////////////////
   // read data

   logic [31:0] rdWord_ff;
   logic [31:0] nxt_rdWord;

   always_comb begin
      nxt_rdWord = `RST_WORD;
      if (regRd) begin
         case (regAddr)
            `OFS_IRQ_EN: begin
               nxt_rdWord = {17'h0_0000, irqEn_ff};
            end
            `OFS_IRQ_TRIG: begin
               nxt_rdWord = {29'h0000_0000, trig_ff};
            end
            `OFS_DATA: begin // see R21
               if (rxCount_ff != '0) begin
                  nxt_rdWord = {24'h00_0000, rxHead[`BYTE_BITS-1:0]};
               end
            end
            `OFS_MODE: begin
               nxt_rdWord = {30'h0000_0000, mode_ff};
            end
            `OFS_STATUS: begin
               nxt_rdWord = {26'h000_0000, frame_ff, parity_ff, overrun_ff,
                  idleCond, txSpaceCond, rxAvailCond};
            end
            default: begin
               nxt_rdWord = `RST_WORD;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdWord_ff <= `RST_WORD;
      end else begin
         rdWord_ff <= nxt_rdWord;
      end
   end

   assign regRdData = rdWord_ff;

endmodule // serial_ctrl_common_regs

//--- test/serial_regs_monitor.sv
// checker for the serial controller common registers
// assumes one clock domain and the register map of serial_defs.svh
`timescale 1ns/1ps
`include "serial_defs.svh"
module serial_regs_monitor import serial_pkg::*; #(
   parameter bit FIRST_UNIT = 1'b1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   input wire logic [7:0] txByte,
   input wire logic txValid,
   input wire logic rxPush,
   input wire logic underrunFlag,
   input wire logic noAckFlag,
   input wire logic dmaOverrunA,
   input wire logic [1:0] modeSel,
   input wire logic irqReq,
   input wire logic overrunFlag,
   input wire logic parityErrFlag
);
   irq_vec_t enShadow_ff;

   // copy of the enable mask
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         enShadow_ff <= `RST_EN;
      end else if (regWr && regAddr == `OFS_IRQ_EN) begin
         enShadow_ff <= regWrData[14:0] & {FIRST_UNIT, FIRST_UNIT, 13'h1fff};
      end
   end

   ////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence dataRd;
      regRd && regAddr == `OFS_DATA;
   endsequence
   sequence dataWr;
      regWr && regAddr == `OFS_DATA;
   endsequence
   property txLoad;
      dataWr ##0 !txValid |=> txValid && txByte == $past(regWrData[7:0]);
   endproperty

   rd_idle_a: assert property (!regRd |=> regRdData == `RST_WORD)
      else $error("read data nonzero outside answer cycle");
   data_top_a: assert property (dataRd |=> !(|regRdData[31:8]))
      else $error("data port upper bits not zero");
   en_read_a: assert property (regRd && regAddr == `OFS_IRQ_EN
      |=> regRdData == 32'($past(enShadow_ff)))
      else $error("enable mask read back wrong");
   mode_wr_a: assert property (regWr && regAddr == `OFS_MODE
      && (FIRST_UNIT || regWrData[1:0] != `MODE_UART)
      |=> modeSel == $past(regWrData[1:0]))
      else $error("mode field not taken from write");
   mode_rd_a: assert property (regRd && regAddr == `OFS_MODE
      |=> regRdData == 32'($past(modeSel)))
      else $error("mode field read back wrong");
   tx_load_a: assert property (txLoad)
      else $error("written byte not at transmit head");
   ovr_clr_a: assert property (dataRd ##0 !rxPush |=> !overrunFlag)
      else $error("overrun not cleared by data read");
   mask_off_a: assert property (enShadow_ff == `RST_EN
      |=> !irqReq)
      else $error("request with every enable clear");
   level_src_a: assert property (enShadow_ff[`BIT_UNDERRUN]
      && underrunFlag || enShadow_ff[8] && noAckFlag |=> irqReq)
      else $error("enabled level source gave no request");
   dma_ovr_a: assert property (enShadow_ff[`BIT_OVERRUN] && dmaOverrunA
      |=> irqReq)
      else $error("buffer overrun gave no request");
   parity_irq_a: assert property (enShadow_ff[`BIT_PARITY_EN]
      && parityErrFlag |=> irqReq)
      else $error("parity error gave no request");
endmodule // serial_regs_monitor

bind serial_ctrl_common_regs serial_regs_monitor
   #(.FIRST_UNIT(FIRST_UNIT)) mon (
   .mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txByte(txByte),
   .txValid(txValid), .rxPush(rxPush), .underrunFlag(underrunFlag),
   .noAckFlag(noAckFlag), .dmaOverrunA(dmaOverrunA), .modeSel(modeSel),
   .irqReq(irqReq), .overrunFlag(overrunFlag),
   .parityErrFlag(parityErrFlag));

//--- test/tb.sv
// self-checking bench for the serial controller common registers
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`include "serial_defs.svh"
module tb import serial_pkg::*; ;
   logic mclk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic txPop = 1'b0, txShiftIdle = 1'b0, rxPush = 1'b0;
   logic rxParErr = 1'b0, rxFrmErr = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [31:0] regWrData = `RST_WORD;
   byte_t rxByte = 8'h00;
   logic [13:3] srcLvl = 11'h000;
   logic [31:0] regRdData;
   logic [7:0] txByte;
   logic [1:0] modeSel;
   logic [31:0] rd2;
   logic [1:0] mode2;
   logic txValid, irqReq, overrunFlag, parityErrFlag, frameErrFlag;
   logic [2:0] errs;
   logic [15:0] adr [5] = '{`OFS_IRQ_EN, `OFS_IRQ_TRIG, `OFS_DATA,
      `OFS_MODE, 16'ha800};
   int checks = 0, num_errors = 0, cyc = 0;

   assign errs = {frameErrFlag, parityErrFlag, overrunFlag};
   always #12.5 mclk = ~mclk;

   serial_ctrl_common_regs #(.FIRST_UNIT(1'b1)) dut (
      .mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txPop(txPop),
      .txShiftIdle(txShiftIdle), .txByte(txByte), .txValid(txValid),
      .rxPush(rxPush), .rxByte(rxByte), .rxParErr(rxParErr),
      .rxFrmErr(rxFrmErr), .noAckFlag(srcLvl[8]),
      .busCmdDoneFlag(srcLvl[7]), .byteSentFlag(srcLvl[6]),
      .byteGotFlag(srcLvl[5]), .txBufBUnloaded(srcLvl[12]),
      .txBufAUnloaded(srcLvl[11]), .rxBufBUnloaded(srcLvl[10]),
      .rxBufAUnloaded(srcLvl[9]), .underrunFlag(srcLvl[4]),
      .dmaOverrunA(srcLvl[3]), .dmaOverrunB(srcLvl[13]),
      .modeSel(modeSel), .irqReq(irqReq), .overrunFlag(overrunFlag),
      .parityErrFlag(parityErrFlag), .frameErrFlag(frameErrFlag));

   // second unit: no uart mode, no error enables
   serial_ctrl_common_regs #(.FIRST_UNIT(1'b0)) dut2 (
      .mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(rd2), .txPop(txPop),
      .txShiftIdle(txShiftIdle), .txByte(), .txValid(),
      .rxPush(rxPush), .rxByte(rxByte), .rxParErr(rxParErr),
      .rxFrmErr(rxFrmErr), .noAckFlag(srcLvl[8]),
      .busCmdDoneFlag(srcLvl[7]), .byteSentFlag(srcLvl[6]),
      .byteGotFlag(srcLvl[5]), .txBufBUnloaded(srcLvl[12]),
      .txBufAUnloaded(srcLvl[11]), .rxBufBUnloaded(srcLvl[10]),
      .rxBufAUnloaded(srcLvl[9]), .underrunFlag(srcLvl[4]),
      .dmaOverrunA(srcLvl[3]), .dmaOverrunB(srcLvl[13]),
      .modeSel(mode2), .irqReq(), .overrunFlag(),
      .parityErrFlag(), .frameErrFlag());

   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      #1 regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rc(input logic [15:0] a, input logic [31:0] e);
      #1 regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 chk(regRdData, e);
   endtask
   task automatic push(input byte_t b, input logic p, input logic f);
      #1 rxByte <= b;
      rxParErr <= p;
      rxFrmErr <= f;
      rxPush <= 1'b1;
      @(posedge mclk);
      rxPush <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // counts request cycles in a window
   task automatic cnt(input int n, input int e);
      int k;
      k = 0;
      repeat (n) begin
         tick(1);
         if (irqReq === 1'b1) begin
            k++;
         end
      end
      chk(32'(k), 32'(e));
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         conclude();
      end
   end

   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      tick(1);
      foreach (adr[k]) begin
         rc(adr[k], `RST_WORD);
      end
      wr(`OFS_IRQ_EN, 32'h0000_7fff);
      rc(`OFS_IRQ_EN, 32'h0000_7fff);
      chk(rd2, 32'h0000_1fff);
      wr(`OFS_IRQ_EN, `RST_WORD);
      wr(`OFS_IRQ_TRIG, 32'h0000_0007);
      rc(`OFS_IRQ_TRIG, 32'h0000_0007);
      wr(16'ha800, 32'h0000_ffff);
      rc(16'ha800, `RST_WORD);
      for (int m = 0; m < 4; m++) begin
         wr(`OFS_MODE, 32'(m));
         rc(`OFS_MODE, 32'(m));
         chk(32'(modeSel), 32'(m));
         chk(32'(mode2), m == 1 ? 32'h0000_0000 : 32'(m));
      end
      // level sources, enabled then masked
      for (int i = 3; i < 14; i++) begin
         wr(`OFS_IRQ_EN, 32'h0000_0001 << (i == 13 ? 3 : i));
         srcLvl[i] <= 1'b1;
         tick(3);
         cnt(4, 4);
         wr(`OFS_IRQ_EN, `RST_WORD);
         tick(3);
         cnt(4, 0);
         srcLvl[i] <= 1'b0;
      end
      // transmit fifo filled past full, then drained
      for (int i = 0; i < 5; i++) begin
         wr(`OFS_DATA, 32'h1234_5640 + 32'(i));
      end
      for (int i = 0; i < 4; i++) begin
         tick(2);
         chk(32'({txValid, txByte}), 32'h0000_0140 + 32'(i));
         #1 txPop <= 1'b1;
         @(posedge mclk);
         txPop <= 1'b0;
      end
      tick(2);
      chk(32'(txValid), `RST_WORD);
      // receive side in uart mode
      wr(`OFS_MODE, 32'h0000_0001);
      push(8'ha5, 1'b1, 1'b0);
      push(8'h3c, 1'b0, 1'b1);
      tick(2);
      chk(32'(errs), 32'h0000_0002);
      wr(`OFS_IRQ_EN, 32'h0000_4000);
      tick(3);
      cnt(2, 2);
      rc(`OFS_DATA, 32'h0000_00a5);
      tick(2);
      chk(32'(errs), 32'h0000_0004);
      wr(`OFS_IRQ_EN, 32'h0000_2000);
      tick(3);
      cnt(2, 2);
      rc(`OFS_DATA, 32'h0000_003c);
      tick(2);
      chk(32'(errs), `RST_WORD);
      rc(`OFS_DATA, `RST_WORD);
      wr(`OFS_IRQ_EN, `RST_WORD);
      for (int i = 0; i < 5; i++) begin
         push(8'h11 + 8'(i), 1'b0, 1'b0);
      end
      tick(2);
      chk(32'(errs), 32'h0000_0001);
      rc(`OFS_STATUS, 32'h0000_000b);
      rc(`OFS_DATA, 32'h0000_0011);
      tick(1);
      chk(32'(errs), `RST_WORD);
      for (int i = 1; i < 4; i++) begin
         rc(`OFS_DATA, 32'h0000_0011 + 32'(i));
      end
      // receive available on edge, then on level
      wr(`OFS_IRQ_TRIG, `RST_WORD);
      wr(`OFS_IRQ_EN, 32'h0000_0001);
      push(8'h5a, 1'b0, 1'b0);
      cnt(6, 1);
      push(8'h5b, 1'b0, 1'b0);
      cnt(6, 0);
      rc(`OFS_DATA, 32'h0000_005a);
      rc(`OFS_DATA, 32'h0000_005b);
      wr(`OFS_IRQ_TRIG, 32'h0000_0001);
      push(8'h5c, 1'b0, 1'b0);
      tick(3);
      cnt(4, 4);
      rc(`OFS_DATA, 32'h0000_005c);
      tick(3);
      cnt(3, 0);
      // line idle on edge, then on level
      wr(`OFS_IRQ_EN, 32'h0000_0004);
      wr(`OFS_IRQ_TRIG, `RST_WORD);
      #1 txShiftIdle <= 1'b1;
      cnt(6, 1);
      txShiftIdle <= 1'b0;
      wr(`OFS_IRQ_TRIG, 32'h0000_0004);
      txShiftIdle <= 1'b1;
      tick(3);
      cnt(4, 4);
      conclude();
   end
endmodule // tb
